// [rtl/serial_cfg.svh]
// constants for the asynchronous serial core
`ifndef SERIAL_CFG_SVH
`define SERIAL_CFG_SVH
// ==========================================================
// register byte addresses
`define OFS_STATUS 4'h0
`define OFS_DATA 4'h4
`define OFS_BAUD 4'h8
`define OFS_CTRL 4'hc
// ==========================================================
// status bit positions
`define ST_TX_EMPTY 7
`define ST_TX_DONE 6
`define ST_RX_FULL 5
`define ST_IDLE 4
`define ST_OVERRUN 3
`define ST_NOISE 2
`define ST_FRAMING 1
// ==========================================================
// control bit positions
`define CT_TX_ON 0
`define CT_RX_ON 1
`define CT_BREAK 2
`define CT_WORD9 3
`define CT_TX_NINTH 4
`define CT_TXE_IE 5
`define CT_TXD_IE 6
`define CT_RXF_IE 7
`define CT_IDLE_IE 8
`define CT_RX_NINTH 9
// ==========================================================
// baud field positions and prescale values
`define BD_PRE_LO 0
`define BD_PRE_HI 1
`define BD_TX_LO 2
`define BD_TX_HI 4
`define BD_RX_LO 5
`define BD_RX_HI 7
`define PRE_VAL0 11'h001
`define PRE_VAL1 11'h003
`define PRE_VAL2 11'h004
`define PRE_VAL3 11'h00d
// ==========================================================
// oversampling
`define OVS_LAST 4'hf
`define SMP_A 4'h7
`define SMP_B 4'h8
`define SMP_C 4'h9
`define SMP_EVAL 4'h8
`define SMP_N3 4'h1
`define SMP_N5 4'h3
`define SMP_N7 4'h5
`define BITS_8 4'h8
`define BITS_9 4'h9
`define FRAME_8 4'ha
`define FRAME_9 4'hb
`define IDLE_LEN_8 8'ha0
`define IDLE_LEN_9 8'hb0
// ==========================================================
// reset values
`define RST_STATUS_TX 1'b1
`define RST_BAUD 8'h00
`endif

// [rtl/serial_pkg.sv]
// types shared by the serial core
package serial_pkg;
  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } rx_state_t;
  typedef enum logic [1:0] {
    FR_DATA = 2'b00,
    FR_IDLE = 2'b01,
    FR_BREAK = 2'b11,
    FR_MARK = 2'b10
  } frame_kind_t;
endpackage

// [rtl/baud_div.sv]
// 16x oversampling tick generator: prescale times power-of-two divider
`timescale 1ns/100ps
`include "serial_cfg.svh"
module baud_div (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_pre_sel,
  input wire logic [2:0] i_div_sel,
  output logic o_tick
);
  logic [10:0] cnt;
  logic [10:0] limit;

  function automatic logic [10:0] pre_val(input logic [1:0] sel);
    case (sel)
      2'h0: pre_val = `PRE_VAL0;
      2'h1: pre_val = `PRE_VAL1;
      2'h2: pre_val = `PRE_VAL2;
      default: pre_val = `PRE_VAL3;
    endcase
  endfunction

  // shared prescale times own divider, minus one
  assign limit = 11'((pre_val(i_pre_sel) << i_div_sel) - 11'h001);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 11'h000;
      o_tick <= 1'b0;
    end else if (cnt >= limit) begin
      cnt <= 11'h000;
      o_tick <= 1'b1;
    end else begin
      cnt <= cnt + 11'h001;
      o_tick <= 1'b0;
    end
  end
endmodule

// [rtl/serial_tx.sv]
// transmitter: holding buffer, frame shifter, idle and break frames
`timescale 1ns/100ps
`include "serial_cfg.svh"
module serial_tx (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_tx_on,
  input wire logic i_word9,
  input wire logic i_send_break,
  input wire logic i_wr,
  input wire logic [8:0] i_wdata,
  output logic o_empty_set,
  output logic o_done_set,
  output logic o_serial
);
  import serial_pkg::*;
  logic [8:0] hold;
  logic hold_full;
  logic [10:0] shifter;
  logic [3:0] bits_left;
  logic [3:0] sub;
  logic busy;
  frame_kind_t kind;
  logic tx_on_q;
  logic idle_pend;
  logic after_break;
  logic bit_end;
  logic pick;
  logic [3:0] flen;

  assign flen = i_word9 ? `FRAME_9 : `FRAME_8;
  assign bit_end = busy && i_tick && (sub == `OVS_LAST);
  // choose a new frame when idle or at the last bit's end
  assign pick = i_tx_on && (!busy || (bit_end && bits_left == 4'h1));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_on_q <= 1'b0;
      idle_pend <= 1'b0;
    end else begin
      tx_on_q <= i_tx_on;
      if (i_tx_on && !tx_on_q) begin
        idle_pend <= 1'b1;
      end else if (pick) begin
        idle_pend <= 1'b0;
      end
    end
  end

  // ==========================================================
  // holding buffer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold <= 9'h000;
      hold_full <= 1'b0;
    end else if (!i_tx_on) begin
      hold_full <= 1'b0;
    end else if (i_wr) begin
      hold <= i_wdata;
      hold_full <= 1'b1;
    end else if (pick && !idle_pend && !i_send_break && !after_break && hold_full) begin
      hold_full <= 1'b0;
    end
  end

  // ==========================================================
  // frame shifter
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shifter <= 11'h7ff;
      bits_left <= 4'h0;
      sub <= 4'h0;
      busy <= 1'b0;
      kind <= FR_IDLE;
      after_break <= 1'b0;
      o_empty_set <= 1'b0;
      o_done_set <= 1'b0;
    end else begin
      o_empty_set <= 1'b0;
      o_done_set <= bit_end && bits_left == 4'h1 && (kind == FR_DATA || kind == FR_BREAK);
      if (bit_end) begin
        sub <= 4'h0;
        shifter <= {1'b1, shifter[10:1]};
        bits_left <= bits_left - 4'h1;
        if (bits_left == 4'h1) begin
          busy <= 1'b0;
        end
      end else if (busy && i_tick) begin
        sub <= sub + 4'h1;
      end
      if (pick) begin
        busy <= 1'b1;
        sub <= 4'h0;
        bits_left <= flen;
        if (idle_pend) begin
          kind <= FR_IDLE;
          shifter <= 11'h7ff;
        end else if (i_send_break) begin
          kind <= FR_BREAK;
          shifter <= 11'h000;
          after_break <= 1'b1;
        end else if (after_break) begin
          kind <= FR_MARK;
          shifter <= 11'h7ff;
          bits_left <= 4'h1;
          after_break <= 1'b0;
        end else if (hold_full) begin
          kind <= FR_DATA;
          // start low, data lsb first, stop high
          shifter <= i_word9 ? {1'b1, hold, 1'b0} : {2'b11, hold[7:0], 1'b0};
          o_empty_set <= 1'b1;
        end else begin
          busy <= 1'b0;
        end
      end
    end
  end

  assign o_serial = busy ? shifter[0] : 1'b1;
endmodule

// [rtl/serial_core.sv]
// asynchronous serial core top: Avalon-MM registers, receiver, flags
// Behaviour
// - status read then data write clears tx empty and tx done flags.
// - tx empty sets when holding buffer empties into shifter; interrupts if enabled.
// - data write during a frame waits in holding buffer until frame ends.
// - data write while idle starts sending at once and tx empty sets again.
// - tx done sets after stop bit or break frame; interrupts if enabled.
// - break control sends zero frames repeatedly, then one high bit afterwards.
// - enabling the transmitter sends one all-ones idle frame first; with break set in the same write, one break frame goes before it.
// - toggling transmit enable queues an idle frame and drops held data.
// - receiver takes 8 or 9 bits; ninth bit goes to control field.
// - receive shifts lsb first through a receive holding buffer.
// - enabling receiver starts hunting for a start bit.
// - each character arriving while rx full is clear fills holding buffer, sets rx full, interrupts if enabled.
// - status read then data read clears rx full; else overrun follows.
// - a received break is handled as a framing error.
// - idle frame acts as a character and interrupts when idle enable set.
// - character while full sets overrun, keeps buffer, interrupts if enabled.
// - data bit valid only if samples 8, 9, 10 agree, else noise.
// - start bit with disagreeing samples is dropped; noise reported next frame.
// - missing stop bit or break sets framing flag; data still transferred.
// - tx and rx rates independent: clock over 16, prescale, own divider.
// - prescale 1, 3, 4 or 13; dividers power of two 1 to 128.
// - output low for start, high for stop, idles high otherwise.
// - each bit sampled 16 times; majority of samples 8, 9, 10.
`timescale 1ns/100ps
`include "serial_cfg.svh"
module serial_core (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_cpu_mask,
  input wire logic i_serial_in_pin,
  output logic o_serial_out,
  output logic o_serial_oe,
  output logic o_irq
);
  import serial_pkg::*;

  // ==========================================================
  // bus handshake: one wait cycle, read data registered
  logic acked;
  logic take;
  logic rd_status, rd_data, wr_data, wr_baud, wr_ctrl;
  logic [31:0] next_readdata;

  assign o_waitrequest = (i_read || i_write) && !acked;
  assign take = (i_read || i_write) && acked;
  assign rd_status = take && i_read && i_address == `OFS_STATUS;
  assign rd_data = take && i_read && i_address == `OFS_DATA;
  assign wr_data = take && i_write && i_byteenable[0] && i_address == `OFS_DATA;
  assign wr_baud = take && i_write && i_byteenable[0] && i_address == `OFS_BAUD;
  assign wr_ctrl = take && i_write && i_byteenable[0] && i_address == `OFS_CTRL;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acked <= 1'b0;
    end else begin
      acked <= (i_read || i_write) && !acked;
    end
  end

  // ==========================================================
  // control and baud registers
  logic tx_on, rx_on, send_break, word9, tx_ninth;
  logic tx_empty_irq_en, tx_done_irq_en, rx_full_irq_en, idle_irq_en;
  logic [7:0] baud_config_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_on <= 1'b0;
      rx_on <= 1'b0;
      send_break <= 1'b0;
      word9 <= 1'b0;
      tx_ninth <= 1'b0;
      tx_empty_irq_en <= 1'b0;
      tx_done_irq_en <= 1'b0;
      rx_full_irq_en <= 1'b0;
      idle_irq_en <= 1'b0;
    end else if (wr_ctrl) begin
      tx_on <= i_writedata[`CT_TX_ON];
      rx_on <= i_writedata[`CT_RX_ON];
      send_break <= i_writedata[`CT_BREAK];
      word9 <= i_writedata[`CT_WORD9];
      tx_ninth <= i_writedata[`CT_TX_NINTH];
      tx_empty_irq_en <= i_writedata[`CT_TXE_IE];
      tx_done_irq_en <= i_writedata[`CT_TXD_IE];
      rx_full_irq_en <= i_writedata[`CT_RXF_IE];
      idle_irq_en <= i_writedata[`CT_IDLE_IE];
    end
  end

  // not guarded against writes while enabled; software keeps it stable
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      baud_config_reg <= `RST_BAUD;
    end else if (wr_baud) begin
      baud_config_reg <= i_writedata[7:0];
    end
  end

  // ==========================================================
  // baud ticks, one divider per direction
  logic tx_tick, rx_tick;

  baud_div u_tx_baud (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pre_sel(baud_config_reg[`BD_PRE_HI:`BD_PRE_LO]),
    .i_div_sel(baud_config_reg[`BD_TX_HI:`BD_TX_LO]),
    .o_tick(tx_tick)
  );

  baud_div u_rx_baud (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pre_sel(baud_config_reg[`BD_PRE_HI:`BD_PRE_LO]),
    .i_div_sel(baud_config_reg[`BD_RX_HI:`BD_RX_LO]),
    .o_tick(rx_tick)
  );

  // ==========================================================
  // transmitter
  logic tx_empty_set, tx_done_set, tx_line;

  serial_tx u_tx (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_tick(tx_tick),
    .i_tx_on(tx_on),
    .i_word9(word9),
    .i_send_break(send_break),
    .i_wr(wr_data),
    .i_wdata({tx_ninth, i_writedata[7:0]}),
    .o_empty_set(tx_empty_set),
    .o_done_set(tx_done_set),
    .o_serial(tx_line)
  );

  assign o_serial_out = tx_line;
  assign o_serial_oe = tx_on || rx_on;

  // ==========================================================
  // input synchroniser
  logic rx_meta, rx_pin;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_meta <= 1'b1;
      rx_pin <= 1'b1;
    end else begin
      rx_meta <= i_serial_in_pin;
      rx_pin <= rx_meta;
    end
  end

  // ==========================================================
  // receiver sampling
  rx_state_t rx_state;
  logic [2:0] hist;
  logic [3:0] smp;
  logic [2:0] mid;
  logic [3:0] bit_idx;
  logic [8:0] rx_shift;
  logic frame_noise, frame_bad;
  logic noise_pend;
  logic [7:0] high_run;
  logic idle_armed;
  logic char_done;
  logic [8:0] char_data;
  logic char_noise, char_framing, char_idle;
  logic maj;
  logic split;

  function automatic logic majority3(input logic [2:0] s);
    majority3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction

  // mid holds samples 8 and 9 when sample 10 arrives
  assign maj = majority3({mid[1:0], rx_pin});
  assign split = !(mid[1:0] == {rx_pin, rx_pin});

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_state <= RX_HUNT;
      hist <= 3'b000;
      smp <= 4'h0;
      mid <= 3'b000;
      bit_idx <= 4'h0;
      rx_shift <= 9'h000;
      frame_noise <= 1'b0;
      frame_bad <= 1'b0;
      noise_pend <= 1'b0;
      high_run <= 8'h00;
      idle_armed <= 1'b0;
      char_done <= 1'b0;
      char_data <= 9'h000;
      char_noise <= 1'b0;
      char_framing <= 1'b0;
      char_idle <= 1'b0;
    end else begin
      char_done <= 1'b0;
      if (!rx_on) begin
        rx_state <= RX_HUNT;
        hist <= 3'b000;
        idle_armed <= 1'b1;
        high_run <= 8'h00;
      end else if (rx_tick) begin
        mid <= {mid[1:0], rx_pin};
        case (rx_state)
          RX_HUNT: begin
            hist <= {hist[1:0], rx_pin};
            // valid edge needs three high samples before it
            if (hist == 3'b111 && !rx_pin) begin
              rx_state <= RX_START;
              smp <= 4'h0;
              frame_noise <= noise_pend;
              frame_bad <= 1'b0;
            end
            if (rx_pin) begin
              if (idle_armed && high_run == (word9 ? `IDLE_LEN_9 : `IDLE_LEN_8)) begin
                idle_armed <= 1'b0;
                char_done <= 1'b1;
                char_data <= 9'h1ff;
                char_noise <= 1'b0;
                char_framing <= 1'b0;
                char_idle <= 1'b1;
              end else begin
                high_run <= high_run + 8'h01;
              end
            end else begin
              high_run <= 8'h00;
            end
          end
          RX_START: begin
            smp <= smp + 4'h1;
            if ((smp == `SMP_N3 || smp == `SMP_N5 || smp == `SMP_N7) && rx_pin) begin
              frame_noise <= 1'b1;
            end
            if (smp == `SMP_EVAL && (split || maj)) begin
              rx_state <= RX_HUNT;
              hist <= 3'b000;
              noise_pend <= 1'b1;
            end else if (smp == `OVS_LAST) begin
              rx_state <= RX_DATA;
              bit_idx <= 4'h0;
            end
          end
          RX_DATA: begin
            smp <= smp + 4'h1;
            if (smp == `SMP_EVAL) begin
              rx_shift <= {maj, rx_shift[8:1]};
              if (split) begin
                frame_noise <= 1'b1;
              end
            end
            if (smp == `OVS_LAST) begin
              bit_idx <= bit_idx + 4'h1;
              if (bit_idx == (word9 ? `BITS_9 : `BITS_8) - 4'h1) begin
                rx_state <= RX_STOP;
              end
            end
          end
          default: begin
            smp <= smp + 4'h1;
            if (smp == `SMP_EVAL) begin
              // a break ends with a low stop bit, so it lands here too
              rx_state <= RX_HUNT;
              hist <= 3'b000;
              high_run <= 8'h00;
              idle_armed <= 1'b1;
              noise_pend <= 1'b0;
              char_done <= 1'b1;
              char_data <= word9 ? rx_shift : {1'b0, rx_shift[8:1]};
              char_noise <= frame_noise || split;
              char_framing <= !maj;
              char_idle <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // receive holding buffer and status flags
  logic [8:0] rx_holding_buffer;
  logic rx_ninth_bit;
  logic tx_empty_flag, tx_done_flag, rx_full_flag, idle_flag;
  logic overrun_flag, noise_flag, framing_flag;
  logic armed;
  logic [7:0] seen;
  logic clr_tx, clr_rx;

  // clear sequence only removes flags that the status read showed
  assign clr_tx = armed && wr_data;
  assign clr_rx = armed && rd_data;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      armed <= 1'b0;
      seen <= 8'h00;
    end else if (rd_status) begin
      armed <= 1'b1;
      // snapshot what software is handed, not what stands one cycle later
      seen <= o_readdata[7:0];
    end else if (rd_data || wr_data) begin
      armed <= 1'b0;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_empty_flag <= `RST_STATUS_TX;
      tx_done_flag <= `RST_STATUS_TX;
    end else begin
      if (tx_empty_set) begin
        tx_empty_flag <= 1'b1;
      end else if (clr_tx && seen[`ST_TX_EMPTY]) begin
        tx_empty_flag <= 1'b0;
      end
      if (tx_done_set) begin
        tx_done_flag <= 1'b1;
      end else if (clr_tx && seen[`ST_TX_DONE]) begin
        tx_done_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_holding_buffer <= 9'h000;
      rx_ninth_bit <= 1'b0;
      rx_full_flag <= 1'b0;
      idle_flag <= 1'b0;
      overrun_flag <= 1'b0;
      noise_flag <= 1'b0;
      framing_flag <= 1'b0;
    end else begin
      if (char_done && rx_full_flag) begin
        overrun_flag <= 1'b1;
      end else if (clr_rx && seen[`ST_OVERRUN]) begin
        overrun_flag <= 1'b0;
      end
      if (char_done && !rx_full_flag) begin
        rx_holding_buffer <= char_data;
        rx_ninth_bit <= word9 & char_data[8];
        rx_full_flag <= 1'b1;
        if (char_idle) begin
          idle_flag <= 1'b1;
        end
        if (char_noise) begin
          noise_flag <= 1'b1;
        end
        if (char_framing) begin
          framing_flag <= 1'b1;
        end
      end else if (clr_rx) begin
        rx_full_flag <= rx_full_flag && !seen[`ST_RX_FULL];
        idle_flag <= idle_flag && !seen[`ST_IDLE];
        noise_flag <= noise_flag && !seen[`ST_NOISE];
        framing_flag <= framing_flag && !seen[`ST_FRAMING];
      end
    end
  end

  // ==========================================================
  // read mux
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (i_address == `OFS_STATUS) begin
      next_readdata[`ST_TX_EMPTY] = tx_empty_flag;
      next_readdata[`ST_TX_DONE] = tx_done_flag;
      next_readdata[`ST_RX_FULL] = rx_full_flag;
      next_readdata[`ST_IDLE] = idle_flag;
      next_readdata[`ST_OVERRUN] = overrun_flag;
      next_readdata[`ST_NOISE] = noise_flag;
      next_readdata[`ST_FRAMING] = framing_flag;
    end else if (i_address == `OFS_DATA) begin
      next_readdata[7:0] = rx_holding_buffer[7:0];
    end else if (i_address == `OFS_BAUD) begin
      next_readdata[7:0] = baud_config_reg;
    end else if (i_address == `OFS_CTRL) begin
      next_readdata[`CT_TX_ON] = tx_on;
      next_readdata[`CT_RX_ON] = rx_on;
      next_readdata[`CT_BREAK] = send_break;
      next_readdata[`CT_WORD9] = word9;
      next_readdata[`CT_TX_NINTH] = tx_ninth;
      next_readdata[`CT_TXE_IE] = tx_empty_irq_en;
      next_readdata[`CT_TXD_IE] = tx_done_irq_en;
      next_readdata[`CT_RXF_IE] = rx_full_irq_en;
      next_readdata[`CT_IDLE_IE] = idle_irq_en;
      next_readdata[`CT_RX_NINTH] = rx_ninth_bit;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_readdata <= 32'h0000_0000;
    end else if (i_read && !acked) begin
      o_readdata <= next_readdata;
    end
  end

  // ==========================================================
  // interrupt request, gated by the cpu mask bit
  assign o_irq = !i_cpu_mask && ((tx_empty_flag && tx_empty_irq_en) ||
                                 (tx_done_flag && tx_done_irq_en) ||
                                 ((rx_full_flag || overrun_flag) && rx_full_irq_en) ||
                                 (idle_flag && idle_irq_en));
endmodule

// [dv/serial_core_props.sv]
// assertion checker for the serial core ports
`timescale 1ns/100ps
module serial_core_props (
  input logic i_clk,
  input logic i_rst_n,
  input logic [3:0] i_address,
  input logic i_read,
  input logic i_write,
  input logic i_cpu_mask,
  input logic [31:0] o_readdata,
  input logic o_waitrequest,
  input logic o_serial_out,
  input logic o_serial_oe,
  input logic o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ====================
  // bus and line relations
  AST_ONE_WAIT: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("late answer");
  AST_WAIT_RISE: assert property ($rose(i_read) |-> o_waitrequest)
    else $error("read taken early");
  AST_STATUS_ZERO: assert property (i_read && o_waitrequest && i_address == 4'h0
    |=> o_readdata[31:8] == 24'h0 && !o_readdata[0]) else $error("status spare bits");
  AST_UNMAPPED: assert property (i_read && o_waitrequest && i_address[1:0] != 2'h0
    |=> o_readdata == 32'h0) else $error("unmapped read not zero");
  AST_MASK_QUIET: assert property (i_cpu_mask |-> !o_irq)
    else $error("irq while masked");
  AST_IDLE_HIGH: assert property (!o_serial_oe |-> o_serial_out)
    else $error("line low while off");
  AST_START_LEN: assert property ($fell(o_serial_out) |-> !o_serial_out [*8])
    else $error("short low bit");
  AST_FIRST_IDLE: assert property ($rose(o_serial_oe) |-> o_serial_out [*8])
    else $error("no idle frame");
  AST_RISE_STEP: assert property ($rose(o_serial_out) && o_serial_oe |-> o_serial_out [*8])
    else $error("short high bit");
  cover property (i_read && !o_waitrequest && i_address == 4'h4);
  cover property ($fell(o_serial_out));
  cover property ($rose(o_serial_oe));
endmodule
bind serial_core serial_core_props u_props (.i_clk, .i_rst_n, .i_address, .i_read, .i_write,
  .i_cpu_mask, .o_readdata, .o_waitrequest, .o_serial_out, .o_serial_oe, .o_irq);

// [dv/ser_peer.sv]
// far-side serial equipment model
`timescale 1ns/100ps
module ser_peer #(parameter int BIT = 16) (
  input logic i_clk,
  input logic i_line,
  output logic o_line
);
  logic [7:0] got [4];
  int n_got = 0;
  initial o_line = 1'b1;
  // ====================
  // frame out; a low stop bit is a break, so one high bit follows it
  task automatic send(input logic [7:0] d, input logic stop);
    logic [10:0] f;
    f = {1'b1, stop, d, 1'b0};
    for (int i = 0; i < 11 - int'(stop); i++) begin
      o_line <= f[i];
      repeat (BIT) @(posedge i_clk);
    end
  endtask
  // frame in, sampled mid bit, lsb first
  always begin
    @(negedge i_line);
    for (int i = 0; i < 8; i++) begin
      repeat (i == 0 ? BIT + BIT / 2 : BIT) @(posedge i_clk);
      got[n_got % 4][i] = i_line;
    end
    repeat (BIT) @(posedge i_clk);
    n_got++;
  end
endmodule

// [dv/testbench.sv]
// self-checking bench for the serial core
`timescale 1ns/100ps
`include "serial_cfg.svh"
module testbench;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_read = 1'b0, i_write = 1'b0, i_cpu_mask = 1'b1;
  logic [3:0] i_address = 4'h0;
  logic [31:0] i_writedata = 32'h0, o_readdata, q;
  logic o_waitrequest, o_serial_out, o_serial_oe, o_irq, peer_line;
  int err_total = 0, checked = 0;
  always #2.5 i_clk = ~i_clk;
  serial_core uut (.i_clk, .i_rst_n, .i_address, .i_read, .i_write, .i_writedata,
    .i_byteenable(4'hf), .o_readdata, .o_waitrequest, .i_cpu_mask,
    .i_serial_in_pin(peer_line), .o_serial_out, .o_serial_oe, .o_irq);
  ser_peer u_peer (.i_clk, .i_line(o_serial_out), .o_line(peer_line));
  // ====================
  // verdict, compare, bus access
  task automatic print_verdict;
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // the extra edge up front keeps a release and the next request apart
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= d;
    i_write <= wr;
    i_read <= !wr;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 20);
    q = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
    if (o_waitrequest !== 1'b0) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // each poll is a status read, so it also arms the clear sequence
  task automatic wait_st(input logic [31:0] m);
    int n;
    for (n = 0; n < 300; n++) begin
      bus(1'b0, `OFS_STATUS, 32'h0);
      if ((q & m) !== 32'h0) break;
    end
    if (n == 300) begin
      err_total++;
      print_verdict();
    end
  endtask
  // ====================
  // scenarios
  task automatic s_tx;
    int n;
    rd(`OFS_STATUS, 32'hc0);
    rd(4'h2, 32'h0);
    bus(1'b1, `OFS_BAUD, 32'h0);
    rd(`OFS_BAUD, 32'h0);
    bus(1'b1, `OFS_CTRL, 32'h1);
    repeat (170) @(posedge i_clk);
    bus(1'b0, `OFS_STATUS, 32'h0);
    bus(1'b1, `OFS_DATA, 32'h3c);
    // tx empty sets two edges after the write edge
    @(posedge i_clk);
    rd(`OFS_STATUS, 32'h80);
    bus(1'b1, `OFS_DATA, 32'ha6);
    for (n = 0; n < 900 && u_peer.n_got < 2; n++) @(posedge i_clk);
    chk(u_peer.n_got, 32'h2);
    chk(u_peer.got[0], 32'h3c);
    chk(u_peer.got[1], 32'ha6);
    wait_st(32'h40);
  endtask
  task automatic s_brk;
    bus(1'b1, `OFS_CTRL, 32'h7);
    repeat (300) @(posedge i_clk);
    chk(o_serial_out, 32'h0);
    chk(u_peer.n_got, 32'h3);
    bus(1'b1, `OFS_CTRL, 32'h3);
    repeat (200) @(posedge i_clk);
    chk(o_serial_out, 32'h1);
    chk(u_peer.got[2], 32'h0);
  endtask
  task automatic s_rx;
    bus(1'b1, `OFS_CTRL, 32'h3);
    wait_st(32'h10);
    chk(q, 32'hf0);
    rd(`OFS_DATA, 32'hff);
    u_peer.send(8'ha5, 1'b1);
    wait_st(32'h20);
    chk(q, 32'he0);
    rd(`OFS_DATA, 32'ha5);
    rd(`OFS_STATUS, 32'hc0);
  endtask
  task automatic s_err;
    u_peer.send(8'h5a, 1'b1);
    u_peer.send(8'h33, 1'b1);
    wait_st(32'h08);
    chk(q, 32'he8);
    rd(`OFS_DATA, 32'h5a);
    u_peer.send(8'h00, 1'b0);
    wait_st(32'h20);
    chk(q, 32'he2);
    i_cpu_mask <= 1'b0;
    bus(1'b1, `OFS_CTRL, 32'h83);
    @(posedge i_clk);
    chk(o_irq, 32'h1);
    rd(`OFS_DATA, 32'h0);
    @(posedge i_clk);
    chk(o_irq, 32'h0);
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    s_tx();
    s_brk();
    s_rx();
    s_err();
    print_verdict();
  end
endmodule
